// *** rtl/acr_pkg.sv ***
package acr_pkg;
   // register map: the configuration register sits at index 0x15 of bank 5
   localparam logic [7:0]  ACR_CFG_INDEX    = 8'h15;
   localparam logic [3:0]  ACR_CFG_BANK     = 4'h5;
   // byte address: bank in bits 11:8, index times four in 7:0 (index in bits 7:2) for word alignment
   localparam logic [11:0] ACR_CFG_ADDR     = 12'h554;
   localparam int          ACR_ADDR_W       = 12;
   // field positions
   localparam int          ACR_CLK_HI       = 7;
   localparam int          ACR_CLK_LO       = 6;
   localparam int          ACR_JUST_BIT     = 5;
   localparam int          ACR_PIN_HI       = 3;
   localparam int          ACR_PIN_LO       = 1;
   localparam int          ACR_REF_BIT      = 0;
   // implemented bits: bit 4 is unimplemented
   localparam logic [7:0]  ACR_IMPL_MASK    = 8'hef;
   localparam logic [7:0]  ACR_CFG_RESET    = 8'h00;
   // oscillator divide counts per clock select code
   localparam logic [5:0]  ACR_DIV8_LAST    = 6'h07;
   localparam logic [5:0]  ACR_DIV32_LAST   = 6'h1f;
   localparam logic [5:0]  ACR_DIV64_LAST   = 6'h3f;
   // conversion clock source codes
   typedef enum logic [1:0] {
      ACR_CLK_DIV8  = 2'h0,
      ACR_CLK_DIV32 = 2'h1,
      ACR_CLK_DIV64 = 2'h2,
      ACR_CLK_RC    = 2'h3
   } acr_clk_sel_t;
endpackage

// *** rtl/acr_clk_div.sv ***
`timescale 1ns/1ps
`default_nettype none
// oscillator divider: one-cycle enable pulse every (last + 1) cycles
module acr_clk_div (
   // clock and reset
   input  wire logic       pclk,
   input  wire logic       presetn,
   // control
   input  wire logic [5:0] div_last,
   // output
   output var  logic       div_tick
);
   import acr_pkg::*;

   logic [5:0] cnt_reg;   // running divide count
   logic [5:0] cnt_next;

   assign cnt_next = (cnt_reg >= div_last) ? 6'h00 : cnt_reg + 6'h01;

   // count and pulse at wrap
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg  <= 6'h00;
         div_tick <= 1'b0;
      end else begin
         cnt_reg  <= cnt_next;
         div_tick <= (cnt_reg >= div_last);
      end
   end
endmodule
`default_nettype wire

// *** rtl/acr_adc_config.sv ***
// Contract
// - register at 0x15 bank 5, resets zero
// - bits 7:6 pick conversion clock source
// - justify=1 right, high byte top zero
// - justify=0 left, low byte bottom zero
// - bit 4 ignores writes, reads zero
// - bit 0 picks external or supply reference
// - bits 3:1 turn top pins digital
`timescale 1ns/1ps
`default_nettype none
module acr_adc_config (
   // apb clock and reset
   input  wire logic                          pclk,
   input  wire logic                          presetn,
   // apb slave
   input  wire logic                          psel,
   input  wire logic                          penable,
   input  wire logic                          pwrite,
   input  wire logic [acr_pkg::ACR_ADDR_W-1:0] paddr,
   input  wire logic [31:0]                   pwdata,
   output logic                               pready,
   output logic                               pslverr,
   output logic [31:0]                        prdata,
   // converter side: raw 10-bit result and internal rc clock
   input  wire logic [9:0]                    conv_result,
   input  wire logic                          internal_rc_clock,
   // converter clock enable and settings
   output logic                               conv_clk_en,
   output logic                               ref_source_select,
   output logic                               result_justify,
   // formatted result bytes
   output logic [7:0]                         result_high_byte,
   output logic [7:0]                         result_low_byte,
   // pin roles, 1 = analog input
   output logic [15:0]                        shared_analog_pins
);
   import acr_pkg::*;

   // configuration storage and apb decode
   logic [7:0]   cfg_reg;        // configuration register
   logic [7:0]   cfg_next;
   wire          acc_phase  = psel & penable;
   wire          hit        = (paddr == ACR_CFG_ADDR);
   wire          wr_hit     = acc_phase & pwrite & hit;
   wire          rd_phase   = psel & ~penable & ~pwrite;

   // fields
   wire [1:0]    clk_field  = cfg_reg[ACR_CLK_HI:ACR_CLK_LO];
   wire [2:0]    pin_field  = cfg_reg[ACR_PIN_HI:ACR_PIN_LO];
   acr_clk_sel_t clk_sel;

   // rc clock passes two flip-flops before use
   logic         rc_meta_reg;    // first stage, read only by second
   logic         rc_sync_reg;
   logic         rc_prev_reg;
   wire          rc_rise    = rc_sync_reg & ~rc_prev_reg;

   // divider
   logic [5:0]   div_last;
   logic         div_tick;

   // result formatting
   logic [7:0]   hi_next;
   logic [7:0]   lo_next;

   // write masks out bit 4; only the implemented bits store
   assign cfg_next = wr_hit ? (pwdata[7:0] & ACR_IMPL_MASK) : cfg_reg;

   // apb answers in the access cycle, no wait states
   assign pready  = 1'b1;
   assign pslverr = 1'b0;

   // clock select decode
   assign clk_sel = acr_clk_sel_t'(clk_field);
   assign div_last = (clk_sel == ACR_CLK_DIV8)  ? ACR_DIV8_LAST  :
                     (clk_sel == ACR_CLK_DIV32) ? ACR_DIV32_LAST :
                     ACR_DIV64_LAST;

   // bit 0 goes straight to the reference mux
   assign ref_source_select = cfg_reg[ACR_REF_BIT];
   assign result_justify    = cfg_reg[ACR_JUST_BIT];

   // right justify zeroes top six bits high; left zeroes bottom six low
   assign hi_next = result_justify ? {6'h00, conv_result[9:8]} : conv_result[9:2];
   assign lo_next = result_justify ? conv_result[7:0] : {conv_result[1:0], 6'h00};

   // pin role map: code n makes top n pins of each half digital; code 7 makes all eight digital
   function automatic logic [7:0] acr_half_map(input logic [2:0] code);
      logic [7:0] m;
      m = 8'hff;
      if (code == 3'h7) begin
         m = 8'h00;
      end else begin
         for (int i = 0; i < 8; i++) begin
            if (i >= 8 - int'(code)) begin
               m[i] = 1'b0;
            end
         end
      end
      return m;
   endfunction

   // configuration register and read data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cfg_reg <= ACR_CFG_RESET;
         prdata  <= 32'h0000_0000;
      end else begin
         cfg_reg <= cfg_next;
         if (rd_phase) begin
            prdata <= hit ? {24'h00_0000, cfg_reg & ACR_IMPL_MASK} : 32'h0000_0000;
         end
      end
   end

   // pin map and result bytes from flip-flops
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shared_analog_pins <= 16'hffff;
         result_high_byte   <= 8'h00;
         result_low_byte    <= 8'h00;
      end else begin
         shared_analog_pins <= {acr_half_map(pin_field), acr_half_map(pin_field)};
         result_high_byte   <= hi_next;
         result_low_byte    <= lo_next;
      end
   end

   // synchroniser for the rc clock
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         rc_meta_reg <= 1'b0;
         rc_sync_reg <= 1'b0;
         rc_prev_reg <= 1'b0;
      end else begin
         rc_meta_reg <= internal_rc_clock;
         rc_sync_reg <= rc_meta_reg;
         rc_prev_reg <= rc_sync_reg;
      end
   end

   // converter clock enable: divider tick or rc edge; a source switch
   // could line up an rc edge with a divider tick, so a pulse never follows one in the next cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         conv_clk_en <= 1'b0;
      end else begin
         conv_clk_en <= ~conv_clk_en & ((clk_sel == ACR_CLK_RC) ? rc_rise : div_tick);
      end
   end

   // oscillator divider
   acr_clk_div u_div (
      .pclk     (pclk),
      .presetn  (presetn),
      .div_last (div_last),
      .div_tick (div_tick)
   );
endmodule
`default_nettype wire

// *** bench/acr_adc_config_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module acr_sva import acr_pkg::*; (
   // apb side
   input wire logic        pclk, presetn, psel, penable, pwrite, pready, pslverr,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata, prdata,
   // converter side
   input wire logic [9:0]  conv_result,
   input wire logic        conv_clk_en, ref_source_select, result_justify,
   input wire logic [7:0]  result_high_byte, result_low_byte,
   input wire logic [15:0] shared_analog_pins
);
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   wire wr = psel && penable && pwrite && paddr == ACR_CFG_ADDR; // config stored
   wire rd = psel && !penable && !pwrite;                        // read setup
   // analog mask: top c pins of each group turn digital, all eight for c = 7
   function automatic logic [15:0] amap(input logic [2:0] c);
      logic [7:0] m;
      m = (c == 3'h7) ? 8'h00 : 8'hff >> c;
      return {m, m};
   endfunction
   a_ready_high: assert property (pready && !pslverr) else $error("bad answer");
   a_reset_clear: assert property ($rose(presetn) |->
      !ref_source_select && !result_justify && shared_analog_pins == 16'hffff) else $error("rst");
   a_ref_follow: assert property (wr |=> ref_source_select == $past(pwdata[0]))
      else $error("ref");
   a_just_follow: assert property (wr |=> result_justify == $past(pwdata[5]))
      else $error("justify");
   a_right_fmt: assert property (result_justify |=>
      {result_high_byte, result_low_byte} == {6'h00, $past(conv_result)}) else $error("right");
   a_left_fmt: assert property (!result_justify |=>
      {result_high_byte, result_low_byte} == {$past(conv_result), 6'h00}) else $error("left");
   a_pin_map: assert property (wr |-> ##2
      shared_analog_pins == amap($past(pwdata[3:1], 2))) else $error("pins");
   a_unmapped_zero: assert property (rd && paddr != ACR_CFG_ADDR |=> prdata == 32'h0)
      else $error("unmapped");
   a_read_back: assert property (rd && paddr == ACR_CFG_ADDR |=> prdata[31:8] == 24'h0 &&
      !prdata[4] && prdata[5] == result_justify && prdata[0] == ref_source_select) else $error("rb");
   a_pulse_short: assert property (conv_clk_en |=> !conv_clk_en) else $error("pulse");
endmodule
bind acr_adc_config acr_sva i_acr_sva (.*);
`default_nettype wire

// *** bench/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
module tb;
   import acr_pkg::*;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, rc = 0;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, exp_q[$];
   logic [9:0]  conv = 0;
   logic [7:0]  mirror = 0;
   wire logic   pready, pslverr, clk_en, ref_sel, just;
   wire logic [31:0] prdata;
   wire logic [7:0]  hi, lo;
   wire logic [15:0] pins;
   int          bad_count = 0, checks_done = 0, k;
   always #2.5 pclk = ~pclk;
   acr_adc_config i_acr_adc_config (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
      .pslverr(pslverr), .prdata(prdata), .conv_result(conv), .internal_rc_clock(rc),
      .conv_clk_en(clk_en), .ref_source_select(ref_sel), .result_justify(just),
      .result_high_byte(hi), .result_low_byte(lo), .shared_analog_pins(pins));
   task results;
      if (bad_count == 0 && checks_done > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task chk(input logic [31:0] e, a);
      checks_done++;
      if (e !== a) begin
         bad_count++;
         $display("MISMATCH %0t exp %h got %h", $time, e, a);
      end
   endtask
   // apb transfer; a read notes its expected word
   task xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      if (!w) exp_q.push_back(a == ACR_CFG_ADDR ? {24'h0, mirror} : 32'h0);
      do begin @(posedge pclk); n++; end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin bad_count++; results; end
      psel <= 0; penable <= 0;
      if (w && a == ACR_CFG_ADDR) mirror = d[7:0] & ACR_IMPL_MASK;
   endtask
   // converter clock pulse spacing, measured after two pulses have passed
   task gap(input int e);
      int n, m;
      n = 0;
      m = 0;
      repeat (2) begin
         do begin @(posedge pclk); m++; end while (clk_en !== 1'b1 && m < 300);
      end
      do begin @(posedge pclk); n++; end while (clk_en !== 1'b1 && n < 100);
      if (m >= 300 || n >= 100) begin bad_count++; results; end
      chk(e, n);
   endtask
   // read watcher takes the oldest note
   always @(posedge pclk) if (psel && penable && !pwrite && pready === 1'b1)
      chk(exp_q.pop_front(), prdata);
   // converter inputs move every cycle
   always @(posedge pclk) begin conv <= $urandom; rc <= $urandom; end
   initial begin
      k = $urandom(71);
      repeat (6) @(posedge pclk);
      presetn <= 1;
      xfer(0, ACR_CFG_ADDR, 0);
      // every pin code and clock code, bit 4 always set
      for (k = 0; k < 8; k++) begin
         xfer(1, ACR_CFG_ADDR, $urandom & 32'hffffff21 | 32'h10 | k << 1 | k << 6);
         xfer(0, ACR_CFG_ADDR, 0);
         if (k % 4 == 0) gap(int'(ACR_DIV8_LAST) + 1);
         if (k % 4 == 1) gap(int'(ACR_DIV32_LAST) + 1);
         if (k % 4 == 2) gap(int'(ACR_DIV64_LAST) + 1);
      end
      xfer(1, ACR_CFG_ADDR ^ 12'h4, '1);
      xfer(0, ACR_CFG_ADDR ^ 12'h4, 0);
      xfer(0, ACR_CFG_ADDR, 0);
      // reset in mid-run clears the register
      presetn <= 0;
      mirror = 0;
      repeat (2) @(posedge pclk);
      presetn <= 1;
      xfer(0, ACR_CFG_ADDR, 0);
      results;
   end
endmodule
`default_nettype wire
